// [rtl/tlec_top.sv]
// Contract
// - Torque limiting only under sensorless, zero-speed sensorless or encoder vector control; code gates only lim.active, not o_torque_limit.
// - Mode selector codes: quadrant, terminal, analog, option one, option two.
// - Quadrant mode: limits 1-4 for fwd power, rev regen, rev power, fwd regen.
// - Terminal mode: two switch inputs pick one limit for all states.
// - Analog mode maps full input span linearly to 0..200 percent.
// - Option modes valid only with option board fitted.
// - With enable input assigned, limit only while on; else maximum torque.
// - Without enable input assigned, selected limiting always active.
// - Limits 0..200 percent of torque at maximum current.
// - Torque-limited flag on while limiting acts.
// - With pre-excitation assigned, excite and accept runs only while input on.
// - Pre-excitation drop while running coasts; return restarts per restart mode.
// - Pre-excitation only under the three vector methods.
// - Encoder vector method unavailable for the second motor.
// - Reverse protection blocks frequency opposite to run direction when enabled under vector methods.
// - While limiting under vector methods, deceleration ramp is suspended.
// - Ramp hold only when its enable setting is enabled.
`timescale 1ns/10ps
`default_nettype none
`include "tlec_regs.svh"
module tlec_top
  import tlec_pkg::*;
#(
  parameter int ADC_W = 12
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Input terminals
  input wire logic i_pre_excitation_input,
  input wire logic i_torque_limit_enable_input,
  input wire logic i_limit_switch_one,
  input wire logic i_limit_switch_two,
  input wire logic [ADC_W-1:0] i_analog_limit_input,
  input wire logic i_run_cmd,
  input wire logic i_run_reverse,
  // Drive state
  input wire logic i_powering,
  input wire logic i_torque_at_limit,
  input wire logic i_decel_ramp_req,
  input wire logic signed [15:0] i_freq_cmd,
  // Outputs
  output logic o_torque_limited_flag,
  output logic [7:0] o_torque_limit,
  output logic o_decel_ramp_hold,
  output logic signed [15:0] o_freq_out,
  output logic o_run_allow,
  output logic o_coast,
  output logic o_excite,
  output logic o_restart,
  output logic [3:0] o_restart_mode
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [3:0] method1;
    logic [3:0] method2;
    logic [3:0] mode;
    logic [3:0] ramp_en;
    logic [3:0] rev_en;
    logic [3:0] restart;
    logic motor2;
    logic tl_assigned;
    logic foc_assigned;
    logic opt_fitted;
    logic [31:0] limits;
    logic [31:0] rdata;
    logic flag;
    logic hold;
    logic signed [15:0] freq;
  } tlec_st_t;
  tlec_st_t st_reg, st_next;
  tlec_lim_if lim();
  logic [3:0] method;
  logic vector_ok;
  logic [7:0] wlim;
  logic reverse_bad;
  function automatic logic is_vector(input logic [3:0] m, input logic second);
    is_vector = m == `TLEC_CODE_SLV || m == `TLEC_CODE_ZSLV || (m == `TLEC_CODE_VEC && !second);
  endfunction
  function automatic logic [31:0] ctrl_word(input tlec_st_t s);
    ctrl_word = '0;
    ctrl_word[`TLEC_CTRL_M1_LSB +: 4] = s.method1;
    ctrl_word[`TLEC_CTRL_M2_LSB +: 4] = s.method2;
    ctrl_word[`TLEC_CTRL_MODE_LSB +: 4] = s.mode;
    ctrl_word[`TLEC_CTRL_RAMP_LSB +: 4] = s.ramp_en;
    ctrl_word[`TLEC_CTRL_REV_LSB +: 4] = s.rev_en;
    ctrl_word[`TLEC_CTRL_RST_LSB +: 4] = s.restart;
    ctrl_word[`TLEC_CTRL_SEL2_BIT] = s.motor2;
    ctrl_word[`TLEC_CTRL_TLA_BIT] = s.tl_assigned;
    ctrl_word[`TLEC_CTRL_FOCA_BIT] = s.foc_assigned;
    ctrl_word[`TLEC_CTRL_OPT_BIT] = s.opt_fitted;
  endfunction
  assign method = st_reg.motor2 ? st_reg.method2 : st_reg.method1;
  assign vector_ok = is_vector(method, st_reg.motor2);
  assign lim.vector_ok = vector_ok;
  // ************************************************************
  // Limit selection
  // ************************************************************
  tlec_limit_sel #(
    .ADC_W(ADC_W)
  ) u_sel (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_mode(st_reg.mode[2:0]),
    .i_limits(st_reg.limits),
    .i_opt_fitted(st_reg.opt_fitted),
    .i_tl_assigned(st_reg.tl_assigned),
    .i_torque_limit_enable_input(i_torque_limit_enable_input),
    .i_limit_switch_one(i_limit_switch_one),
    .i_limit_switch_two(i_limit_switch_two),
    .i_analog_limit_input(i_analog_limit_input),
    .i_forward(!i_run_reverse),
    .i_powering(i_powering),
    .lim(lim)
  );
  // ************************************************************
  // Run gating
  // ************************************************************
  tlec_run_gate u_gate (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_foc_assigned(st_reg.foc_assigned),
    .i_vector_ok(vector_ok),
    .i_restart_mode(st_reg.restart),
    .i_pre_excitation_input(i_pre_excitation_input),
    .i_run_cmd(i_run_cmd),
    .o_run_allow(o_run_allow),
    .o_coast(o_coast),
    .o_excite(o_excite),
    .o_restart(o_restart),
    .o_restart_mode(o_restart_mode)
  );
  // ************************************************************
  // Registers and control
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    wlim = (i_wdata[7:0] > `TLEC_LIM_MAX) ? `TLEC_LIM_MAX : i_wdata[7:0];
    if (i_wr)
    begin
      unique case (i_addr)
        `TLEC_OFF_CTRL:
        begin
          st_next.method1 = i_wdata[`TLEC_CTRL_M1_LSB +: 4];
          st_next.method2 = i_wdata[`TLEC_CTRL_M2_LSB +: 4];
          st_next.mode = (i_wdata[`TLEC_CTRL_MODE_LSB +: 4] > 4'h4) ? st_reg.mode : i_wdata[`TLEC_CTRL_MODE_LSB +: 4];
          st_next.ramp_en = i_wdata[`TLEC_CTRL_RAMP_LSB +: 4];
          st_next.rev_en = i_wdata[`TLEC_CTRL_REV_LSB +: 4];
          st_next.restart = i_wdata[`TLEC_CTRL_RST_LSB +: 4];
          st_next.motor2 = i_wdata[`TLEC_CTRL_SEL2_BIT];
          st_next.tl_assigned = i_wdata[`TLEC_CTRL_TLA_BIT];
          st_next.foc_assigned = i_wdata[`TLEC_CTRL_FOCA_BIT];
          st_next.opt_fitted = i_wdata[`TLEC_CTRL_OPT_BIT];
        end
        `TLEC_OFF_LIM1: st_next.limits[7:0] = wlim;
        `TLEC_OFF_LIM2: st_next.limits[15:8] = wlim;
        `TLEC_OFF_LIM3: st_next.limits[23:16] = wlim;
        `TLEC_OFF_LIM4: st_next.limits[31:24] = wlim;
        default: ;
      endcase
    end
    st_next.rdata = '0;
    if (i_rd)
    begin
      unique case (i_addr)
        `TLEC_OFF_CTRL: st_next.rdata = ctrl_word(st_reg);
        `TLEC_OFF_LIM1: st_next.rdata = {24'h00_0000, st_reg.limits[7:0]};
        `TLEC_OFF_LIM2: st_next.rdata = {24'h00_0000, st_reg.limits[15:8]};
        `TLEC_OFF_LIM3: st_next.rdata = {24'h00_0000, st_reg.limits[23:16]};
        `TLEC_OFF_LIM4: st_next.rdata = {24'h00_0000, st_reg.limits[31:24]};
        `TLEC_OFF_STAT: st_next.rdata = {24'h00_0000, o_restart, o_excite, o_coast, o_run_allow,
                                         vector_ok, lim.active, st_reg.hold, st_reg.flag};
        `TLEC_OFF_FREQ: st_next.rdata = {16'h0000, st_reg.freq};
        default: st_next.rdata = '0;
      endcase
    end
    st_next.flag = lim.active && i_torque_at_limit;
    st_next.hold = st_next.flag && vector_ok && st_reg.ramp_en == `TLEC_EN_ON && i_decel_ramp_req;
    reverse_bad = i_run_reverse ? (i_freq_cmd > 16'sh0000) : (i_freq_cmd < 16'sh0000);
    st_next.freq = (vector_ok && st_reg.rev_en == `TLEC_EN_ON && reverse_bad) ? 16'sh0000 : i_freq_cmd;
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_reg <= '0;
      st_reg.limits <= {4{`TLEC_LIM_RESET}};
      st_reg.method1 <= `TLEC_CODE_SLV;
      st_reg.method2 <= `TLEC_CODE_SLV;
    end
    else
      st_reg <= st_next;
  end
  assign o_rdata = st_reg.rdata;
  assign o_torque_limited_flag = st_reg.flag;
  assign o_torque_limit = lim.limit;
  assign o_decel_ramp_hold = st_reg.hold;
  assign o_freq_out = st_reg.freq;
endmodule
`default_nettype wire

// [pkg/tlec_regs.svh]
`ifndef TLEC_REGS_SVH
`define TLEC_REGS_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define TLEC_OFF_CTRL 8'h00
`define TLEC_OFF_LIM1 8'h04
`define TLEC_OFF_LIM2 8'h08
`define TLEC_OFF_LIM3 8'h0C
`define TLEC_OFF_LIM4 8'h10
`define TLEC_OFF_STAT 8'h14
`define TLEC_OFF_FREQ 8'h18
// ************************************************************
// Control fields
// ************************************************************
`define TLEC_CTRL_M1_LSB 0
`define TLEC_CTRL_M2_LSB 4
`define TLEC_CTRL_MODE_LSB 8
`define TLEC_CTRL_RAMP_LSB 12
`define TLEC_CTRL_REV_LSB 16
`define TLEC_CTRL_RST_LSB 20
`define TLEC_CTRL_SEL2_BIT 24
`define TLEC_CTRL_TLA_BIT 25
`define TLEC_CTRL_FOCA_BIT 26
`define TLEC_CTRL_OPT_BIT 27
// ************************************************************
// Reset values and scaling
// ************************************************************
`define TLEC_LIM_RESET 8'hC8
`define TLEC_LIM_MAX 8'hC8
`define TLEC_ADC_FULL 12'hFFF
`define TLEC_CODE_SLV 4'h3
`define TLEC_CODE_ZSLV 4'h4
`define TLEC_CODE_VEC 4'h5
`define TLEC_EN_ON 4'h1
`endif

// [pkg/tlec_pkg.sv]
package tlec_pkg;
  typedef enum logic [2:0] {TLEC_QUAD, TLEC_TERM, TLEC_ANALOG, TLEC_OPT1, TLEC_OPT2} tlec_mode_t;
  typedef enum logic [1:0] {TLEC_STOP, TLEC_RUN, TLEC_COAST} tlec_run_t;
endpackage

// [pkg/tlec_lim_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface tlec_lim_if;
  logic [7:0] limit;
  logic active;
  logic vector_ok;
  modport src (output limit, output active, input vector_ok);
  modport snk (input limit, input active, output vector_ok);
endinterface
`default_nettype wire

// [rtl/tlec_limit_sel.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tlec_regs.svh"
module tlec_limit_sel
  import tlec_pkg::*;
#(
  parameter int ADC_W = 12
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Settings
  input wire logic [2:0] i_mode,
  input wire logic [31:0] i_limits,
  input wire logic i_opt_fitted,
  input wire logic i_tl_assigned,
  // Terminals
  input wire logic i_torque_limit_enable_input,
  input wire logic i_limit_switch_one,
  input wire logic i_limit_switch_two,
  input wire logic [ADC_W-1:0] i_analog_limit_input,
  input wire logic i_forward,
  input wire logic i_powering,
  // Result
  tlec_lim_if.src lim
);
  // Elaboration check on the converter width
  if (ADC_W < 8 || ADC_W > 16)
  begin
    $error("ADC_W out of range");
  end
  typedef struct packed {
    logic [7:0] limit;
    logic active;
  } tlec_sel_st_t;
  tlec_sel_st_t st_reg, st_next;
  logic [ADC_W+7:0] prod;
  function automatic logic [7:0] pick(input logic [31:0] l, input logic [1:0] idx);
    pick = l[idx*8 +: 8];
  endfunction
  always_comb
  begin
    prod = i_analog_limit_input * (ADC_W+8)'(`TLEC_LIM_MAX);
    st_next = st_reg;
    st_next.active = lim.vector_ok;
    unique case (i_mode)
      TLEC_QUAD:
        // Quadrant: 1 fwd power, 2 rev regen, 3 rev power, 4 fwd regen
        st_next.limit = pick(i_limits, i_forward ? (i_powering ? 2'h0 : 2'h3) : (i_powering ? 2'h2 : 2'h1));
      TLEC_TERM:
        st_next.limit = pick(i_limits, {i_limit_switch_two, i_limit_switch_one});
      TLEC_ANALOG:
        st_next.limit = 8'(prod / (ADC_W+8)'((1 << ADC_W) - 1));
      default:
      begin
        // Option modes resolve off-block; hold full torque here
        st_next.limit = `TLEC_LIM_MAX;
        st_next.active = lim.vector_ok && i_opt_fitted;
      end
    endcase
    if (i_tl_assigned && !i_torque_limit_enable_input)
    begin
      st_next.limit = `TLEC_LIM_MAX;
      st_next.active = 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign lim.limit = st_reg.limit;
  assign lim.active = st_reg.active;
endmodule
`default_nettype wire

// [rtl/tlec_run_gate.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tlec_regs.svh"
module tlec_run_gate
  import tlec_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Settings
  input wire logic i_foc_assigned,
  input wire logic i_vector_ok,
  input wire logic [3:0] i_restart_mode,
  // Terminals
  input wire logic i_pre_excitation_input,
  input wire logic i_run_cmd,
  // Status
  output logic o_run_allow,
  output logic o_coast,
  output logic o_excite,
  output logic o_restart,
  output logic [3:0] o_restart_mode
);
  typedef struct packed {
    tlec_run_t state;
    logic restart;
    logic excite;
  } tlec_gate_st_t;
  tlec_gate_st_t st_reg, st_next;
  logic gate_on;
  always_comb
  begin
    gate_on = !i_foc_assigned || !i_vector_ok || i_pre_excitation_input;
    st_next = st_reg;
    st_next.restart = 1'b0;
    st_next.excite = i_foc_assigned && i_vector_ok && i_pre_excitation_input;
    unique case (st_reg.state)
      TLEC_STOP:
        if (i_run_cmd && gate_on)
          st_next.state = TLEC_RUN;
      TLEC_RUN:
        if (!gate_on)
          st_next.state = TLEC_COAST;
        else if (!i_run_cmd)
          st_next.state = TLEC_STOP;
      TLEC_COAST:
        if (!i_run_cmd)
          st_next.state = TLEC_STOP;
        else if (gate_on)
        begin
          st_next.state = TLEC_RUN;
          st_next.restart = 1'b1;
        end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_reg <= '{state: TLEC_STOP, restart: 1'b0, excite: 1'b0};
    else
      st_reg <= st_next;
  end
  assign o_run_allow = st_reg.state == TLEC_RUN;
  assign o_coast = st_reg.state == TLEC_COAST;
  assign o_excite = st_reg.excite;
  assign o_restart = st_reg.restart;
  assign o_restart_mode = i_restart_mode;
endmodule
`default_nettype wire

// [tb/tlec_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module tlec_top_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Inputs
  input wire logic i_run_cmd,
  input wire logic i_pre_excitation_input,
  input wire logic i_torque_at_limit,
  input wire logic i_decel_ramp_req,
  input wire logic signed [15:0] i_freq_cmd,
  // Outputs
  input wire logic o_torque_limited_flag,
  input wire logic [7:0] o_torque_limit,
  input wire logic o_decel_ramp_hold,
  input wire logic signed [15:0] o_freq_out,
  input wire logic o_run_allow,
  input wire logic o_coast,
  input wire logic o_restart
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ************
  // Checks
  // ************
  a_flag_cause: assert property (o_torque_limited_flag |->
    $past(i_torque_at_limit) || $past(i_torque_at_limit, 2)) else $error("flag without cause");
  a_hold_flag: assert property (o_decel_ramp_hold |-> o_torque_limited_flag)
    else $error("hold without flag");
  a_hold_req: assert property (o_decel_ramp_hold |-> $past(i_decel_ramp_req))
    else $error("hold without request");
  a_limit_max: assert property (o_torque_limit <= 8'hC8)
    else $error("limit above full");
  a_run_coast: assert property (!(o_run_allow && o_coast))
    else $error("run while coasting");
  a_restart_pulse: assert property (o_restart |=> !o_restart)
    else $error("restart too long");
  a_restart_src: assert property (o_restart |-> $past(o_coast) && o_run_allow)
    else $error("restart not from coast");
  a_coast_drop: assert property ($rose(o_coast) |-> !$past(i_pre_excitation_input))
    else $error("coast without drop");
  a_freq_block: assert property (o_freq_out != $past(i_freq_cmd) |-> o_freq_out == 16'h0000)
    else $error("freq altered");
  a_run_cmd: assert property ($rose(o_run_allow) |-> $past(i_run_cmd))
    else $error("run without command");
  c_flag: cover property (o_torque_limited_flag);
  c_hold: cover property (o_decel_ramp_hold);
  c_restart: cover property (o_restart);
  c_coast: cover property ($rose(o_coast));
endmodule
bind tlec_top tlec_top_sva u_sva (.i_ref_clk, .i_reset_n, .i_run_cmd, .i_pre_excitation_input,
  .i_torque_at_limit, .i_decel_ramp_req, .i_freq_cmd, .o_torque_limited_flag, .o_torque_limit,
  .o_decel_ramp_hold, .o_freq_out, .o_run_allow, .o_coast, .o_restart);
`default_nettype wire

// [tb/tlec_top_test.sv]
`timescale 1ns/10ps
`default_nettype none
module tlec_top_test;
  logic i_ref_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_run_cmd = 0, i_run_reverse = 0;
  logic i_powering = 0, i_torque_at_limit = 0, i_decel_ramp_req = 0, i_pre_excitation_input = 0;
  logic i_torque_limit_enable_input = 0, i_limit_switch_one = 0, i_limit_switch_two = 0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [11:0] i_analog_limit_input = 12'h000;
  logic signed [15:0] i_freq_cmd = 16'h0000;
  logic [31:0] o_rdata;
  logic o_torque_limited_flag, o_decel_ramp_hold, o_run_allow, o_coast, o_excite, o_restart;
  logic [7:0] o_torque_limit;
  logic signed [15:0] o_freq_out;
  logic [3:0] o_restart_mode;
  int fails = 0, compares = 0, cyc = 0;
  tlec_top dut (.i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pre_excitation_input, .i_torque_limit_enable_input, .i_limit_switch_one, .i_limit_switch_two,
    .i_analog_limit_input, .i_run_cmd, .i_run_reverse, .i_powering, .i_torque_at_limit,
    .i_decel_ramp_req, .i_freq_cmd, .o_torque_limited_flag, .o_torque_limit, .o_decel_ramp_hold,
    .o_freq_out, .o_run_allow, .o_coast, .o_excite, .o_restart, .o_restart_mode);
  // ************
  // Helpers
  // ************
  task automatic e;
    @(posedge i_ref_clk);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    e();
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    e();
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    e();
    i_rd <= 1'b1;
    i_addr <= a;
    e();
    i_rd <= 1'b0;
    w(0);
    chk(o_rdata, x);
  endtask
  function automatic logic [31:0] cw(input logic [3:0] m1, m2, md, rp, rv, rs, b);
    return {4'h0, b, rs, rv, rp, md, m2, m1};
  endfunction
  // ************
  // Scenarios
  // ************
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 + 4 * i), 32'h0000_00C8);
    end
    rd(8'h00, 32'h0000_0033);
    rd(8'h1C, 32'h0000_0000);
    wr(8'h04, 32'h0000_00FF);
    rd(8'h04, 32'h0000_00C8);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'(4 + 4 * i), 32'(10 * i + 10));
    end
  endtask
  task automatic t_quad;
    logic [1:0] q[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    wr(8'h00, cw(4'h3, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0));
    // Torque loop at its limit; low-speed overload restriction lives outside
    i_torque_at_limit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      e();
      {i_run_reverse, i_powering} <= q[i];
      w(3);
      chk(32'(o_torque_limit), 32'(10 * i + 10));
      chk(32'(o_torque_limited_flag), 32'h1);
    end
  endtask
  task automatic t_term;
    wr(8'h00, cw(4'h3, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0));
    for (int i = 0; i < 4; i++)
    begin
      e();
      {i_limit_switch_two, i_limit_switch_one, i_run_reverse, i_powering} <= {2'(i), 2'(3 - i)};
      w(3);
      chk(32'(o_torque_limit), 32'(10 * i + 10));
    end
  endtask
  task automatic t_analog;
    wr(8'h00, cw(4'h3, 4'h3, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0));
    w(3);
    chk(32'(o_torque_limit), 32'h0);
    e();
    i_analog_limit_input <= 12'h800;
    w(3);
    chk(32'(o_torque_limit), 32'h0000_0064);
    e();
    i_analog_limit_input <= 12'hFFF;
    w(3);
    chk(32'(o_torque_limit), 32'h0000_00C8);
  endtask
  task automatic t_opt;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, cw(4'h3, 4'h3, 4'(3 + i[0]), 4'h0, 4'h0, 4'h0, {i[1], 3'b000}));
      w(3);
      chk(32'(o_torque_limited_flag), 32'(i[1]));
      chk(32'(o_torque_limit), 32'h0000_00C8);
    end
  endtask
  task automatic t_enable;
    wr(8'h00, cw(4'h3, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2));
    {i_run_reverse, i_powering} <= 2'b01;
    w(3);
    chk(32'({o_torque_limit, o_torque_limited_flag}), 32'h0000_0190);
    e();
    i_torque_limit_enable_input <= 1'b1;
    w(3);
    chk(32'({o_torque_limit, o_torque_limited_flag}), 32'h0000_0015);
  endtask
  task automatic t_method;
    logic [11:0] tv[5] = '{12'h130, 12'h351, 12'h341, 12'h530, 12'h430};
    logic [4:0] ex = 5'b11100;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h00, cw(tv[i][11:8], tv[i][7:4], 4'h0, 4'h0, 4'h0, 4'h0, tv[i][3:0]));
      w(3);
      chk(32'(o_torque_limited_flag), 32'(ex[i]));
    end
  endtask
  task automatic t_hold;
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, cw(4'h3, 4'h3, 4'h0, 4'(1 - i), 4'h0, 4'h0, 4'h0));
      i_decel_ramp_req <= 1'b1;
      w(3);
      chk(32'(o_decel_ramp_hold), 32'(1 - i));
    end
  endtask
  task automatic t_rev;
    logic [15:0] c[4] = '{16'hFF9C, 16'h0064, 16'h0064, 16'hFF9C};
    logic [15:0] x[4] = '{16'h0000, 16'h0064, 16'h0000, 16'hFF9C};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, cw(4'h3, 4'h3, 4'h0, 4'h0, 4'(i < 3), 4'h0, 4'h0));
      i_run_reverse <= (i == 2);
      i_freq_cmd <= c[i];
      w(3);
      chk({16'h0000, o_freq_out}, {16'h0000, x[i]});
    end
  endtask
  task automatic t_foc;
    logic seen;
    seen = 1'b0;
    wr(8'h00, cw(4'h3, 4'h3, 4'h0, 4'h0, 4'h0, 4'h2, 4'h4));
    i_run_cmd <= 1'b1;
    w(3);
    chk(32'(o_run_allow), 32'h0);
    e();
    i_pre_excitation_input <= 1'b1;
    w(3);
    chk(32'({o_run_allow, o_excite}), 32'h3);
    e();
    i_pre_excitation_input <= 1'b0;
    w(3);
    chk(32'({o_coast, o_run_allow}), 32'h2);
    e();
    i_pre_excitation_input <= 1'b1;
    repeat (4)
    begin
      w(1);
      seen = seen | o_restart;
    end
    chk(32'({seen, o_run_allow, o_restart_mode}), 32'h0000_0032);
    wr(8'h00, cw(4'h1, 4'h3, 4'h0, 4'h0, 4'h0, 4'h2, 4'h4));
    i_pre_excitation_input <= 1'b0;
    w(3);
    chk(32'({o_excite, o_run_allow}), 32'h1);
  endtask
  // ************
  // Run control
  // ************
  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
    forever #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_quad();
    t_term();
    t_analog();
    t_opt();
    t_enable();
    t_method();
    t_hold();
    t_rev();
    t_foc();
    give_verdict();
  end
endmodule
`default_nettype wire
